//--- hdl/cmo_top.sv
// Contract
// - rx pending set on every stored data frame, never cleared by hardware
// - tx pending set after successful transmission, cleared by software only
// - rx updating reads one only while identifier, length and data are written
// - fresh data set once a received frame is fully stored
// - fresh data cleared when transmission of the object starts
// - frame lost set when fresh data is set again while still set
// - invalid objects take no part in reception or transmission
// - selected on receive choice; store skipped if software cleared it
// - selected on transmit choice; rechecked at setup and success; never cleared by hardware
// - rx enable checked only at acceptance; disabled objects accept nothing
// - transmit pending needs request, both enables and valid together
// - matching remote frame received correctly sets transmit request
// - success clears transmit request unless software set fresh data meanwhile
// - both enables needed to transmit; clearing enable a stops remote answers
// - enable b marks the active object of a transmit fifo
// - direction zero: request sends remote frame, data frames are stored
// - direction one: request sends data frame, remote frame sets request
// - list field shows owning list, updated by panel commands
// - previous and next pointers, reset to neighbours clamped at ends
// - rx and tx interrupts routed to lines 0..7, higher codes reserved
// - interrupt sets pending bit chosen by the pending index
// - frame counter copied on store or on successful transmission
// - control word clears with reset alone, sets with set alone
//
// Design decisions made here: the register offsets and the Wishbone register port.
`include "cmo_defs.svh"
`default_nettype none
module cmo_top (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire cmo_pkg::cmo_wb_req_s wb_i,
  output logic                     ack_o,
  output logic [31:0]              dat_o,
  input  wire cmo_pkg::cmo_ev_s    ev_i,
  input  wire cmo_pkg::cmo_panel_s panel_i,
  input  wire cmo_pkg::cmo_fifo_s  fifo_i,
  input  wire logic [15:0]         node_frame_counter_i,
  output logic                     rx_accept_ok_o,
  output logic                     tx_go_o,
  output logic                     tx_abort_o,
  output logic                     tx_data_frame_o,
  output logic [31:0]              tx_pending_o,
  output logic [7:0]               irq_output_line_o
);

  cmo_pkg::cmo_state_s s_reg;
  cmo_pkg::cmo_state_s s_next;
  cmo_pkg::cmo_flags_s cur;
  logic [4:0]          e;
  logic                rx_fire;
  logic                tx_fire;
  logic                store_ok;
  logic                done_ok;
  logic                setup_ok;
  logic [7:0]          line;
  logic                pend_set;
  logic [7:0]          pend_idx;
  logic [31:0]         pend_vec;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) m[b*8 +: 8] = 8'hFF;
    end
    return m;
  endfunction : lane_mask

  function automatic logic pend_of(input cmo_pkg::cmo_flags_s f);
    return f.tx_request_bit & f.tx_enable_a & f.tx_enable_b & f.object_valid_bit;
  endfunction : pend_of

  function automatic cmo_pkg::cmo_state_s reset_state();
    cmo_pkg::cmo_state_s r;
    r = '0;
    r.wb = cmo_pkg::CMO_WB_IDLE;
    for (int n = 0; n < `CMO_NUM_OBJ; n++) begin
      r.obj[n].prev_object_pointer = (n == 0) ? 8'h00 : 8'(n - 1);
      r.obj[n].next_object_pointer = (n == `CMO_NUM_OBJ - 1) ? `CMO_LAST_OBJ : 8'(n + 1);
      r.obj[n].ipr = `CMO_IPR_RESET;
      r.obj[n].fcr = `CMO_FCR_RESET;
    end
    return r;
  endfunction : reset_state

  // ----------------------------------------
  // event qualifiers
  // ----------------------------------------
  assign e        = ev_i.obj;
  assign cur      = s_reg.obj[e].flags;
  assign store_ok = (ev_i.kind == cmo_pkg::CMO_EV_RX_STORE) & cur.object_selected_bit
                  & cur.object_valid_bit & !ev_i.remote & !cur.dir;
  assign done_ok  = (ev_i.kind == cmo_pkg::CMO_EV_TX_DONE) & cur.object_selected_bit
                  & cur.object_valid_bit;
  assign setup_ok = (ev_i.kind == cmo_pkg::CMO_EV_TX_SETUP) & cur.object_selected_bit
                  & pend_of(cur);
  assign rx_fire  = store_ok & s_reg.obj[e].fcr[`CMO_RXIE_BIT];
  assign tx_fire  = done_ok & s_reg.obj[e].fcr[`CMO_TXIE_BIT];

  for (genvar g = 0; g < `CMO_NUM_OBJ; g++) begin : g_pend
    assign pend_vec[g] = pend_of(s_reg.obj[g].flags);
  end

  cmo_irq_route u_route (
    .rx_fire_i            (rx_fire),
    .tx_fire_i            (tx_fire),
    .rx_irq_line_select_i (s_reg.obj[e].ipr[3:0]),
    .tx_irq_line_select_i (s_reg.obj[e].ipr[7:4]),
    .pending_bit_index_i  (s_reg.obj[e].ipr[`CMO_MPN_LO +: 8]),
    .line_o               (line),
    .pend_set_o           (pend_set),
    .pend_idx_o           (pend_idx)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [4:0]  ro;
    logic [2:0]  rw;
    logic [31:0] m;
    logic [11:0] clr;
    logic [11:0] set;
    ro  = wb_i.adr[9:5];
    rw  = wb_i.adr[4:2];
    m   = lane_mask(wb_i.sel);
    clr = '0;
    set = '0;
    s_next          = s_reg;
    s_next.rx_ok    = 1'b0;
    s_next.tx_go    = 1'b0;
    s_next.tx_abort = 1'b0;
    s_next.irq      = line;
    s_next.tx_pend  = pend_vec;

    // bus slave
    unique case (s_reg.wb)
      cmo_pkg::CMO_WB_IDLE: begin
        if (wb_i.cyc && wb_i.stb) begin
          s_next.ack = 1'b1;
          s_next.wb  = cmo_pkg::CMO_WB_ACK;
          s_next.rdat = 32'h0000_0000;
          if (wb_i.adr[11] || (wb_i.adr[`CMO_PEND_AREA] && ro != 5'h00)) begin
            s_next.rdat = 32'h0000_0000;
          end else if (wb_i.adr[`CMO_PEND_AREA]) begin
            s_next.rdat = s_reg.pend[rw*32 +: 32];
            if (wb_i.we) s_next.pend[rw*32 +: 32] = s_reg.pend[rw*32 +: 32] & ~(wb_i.dat & m);
          end else begin
            unique case (rw)
              `CMO_OFS_STAT: begin
                s_next.rdat = {s_reg.obj[ro].next_object_pointer, s_reg.obj[ro].prev_object_pointer,
                               s_reg.obj[ro].list, s_reg.obj[ro].flags};
                if (wb_i.we) begin
                  clr = wb_i.dat[`CMO_RES_LO +: 12] & m[`CMO_RES_LO +: 12];
                  set = wb_i.dat[`CMO_SET_LO +: 12] & m[`CMO_SET_LO +: 12];
                  s_next.obj[ro].flags = (s_reg.obj[ro].flags & ~(clr & ~set)) | (set & ~clr);
                end
              end
              `CMO_OFS_IPR: begin
                s_next.rdat = s_reg.obj[ro].ipr;
                if (wb_i.we) s_next.obj[ro].ipr = (s_reg.obj[ro].ipr & ~m) | (wb_i.dat & m);
              end
              `CMO_OFS_FCR: begin
                s_next.rdat = s_reg.obj[ro].fcr;
                if (wb_i.we) s_next.obj[ro].fcr = (s_reg.obj[ro].fcr & ~m) | (wb_i.dat & m);
              end
              default: s_next.rdat = 32'h0000_0000;
            endcase
          end
        end
      end
      cmo_pkg::CMO_WB_ACK: begin
        s_next.ack = 1'b0;
        s_next.wb  = cmo_pkg::CMO_WB_IDLE;
      end
      default: begin
        s_next.ack = 1'b0;
        s_next.wb  = cmo_pkg::CMO_WB_IDLE;
      end
    endcase

    // panel and fifo updates
    if (panel_i.valid) begin
      s_next.obj[panel_i.obj].list                = panel_i.list;
      s_next.obj[panel_i.obj].prev_object_pointer = panel_i.prev_object_pointer;
      s_next.obj[panel_i.obj].next_object_pointer = panel_i.next_object_pointer;
    end
    if (fifo_i.valid) s_next.obj[fifo_i.obj].flags.tx_enable_b = fifo_i.active;

    // protocol engine events, applied after software so sets win
    unique case (ev_i.kind)
      cmo_pkg::CMO_EV_IDLE: ;
      cmo_pkg::CMO_EV_RX_ACCEPT: begin
        if (cur.object_valid_bit && cur.rx_enable_bit && (ev_i.remote == cur.dir)) begin
          s_next.obj[e].flags.object_selected_bit = 1'b1;
          s_next.rx_ok = 1'b1;
        end
      end
      cmo_pkg::CMO_EV_RX_UPDATE: begin
        if (cur.object_selected_bit && cur.object_valid_bit && !ev_i.remote)
          s_next.obj[e].flags.rx_updating_flag = 1'b1;
      end
      cmo_pkg::CMO_EV_RX_STORE: begin
        s_next.obj[e].flags.rx_updating_flag = 1'b0;
        if (store_ok) begin
          s_next.obj[e].flags.fresh_data_flag = 1'b1;
          s_next.obj[e].flags.rx_pending_flag = 1'b1;
          if (cur.fresh_data_flag) s_next.obj[e].flags.frame_lost_flag = 1'b1;
          s_next.obj[e].ipr[`CMO_CFC_LO +: 16] = node_frame_counter_i;
        end else if (cur.object_selected_bit && cur.object_valid_bit && ev_i.remote
                     && cur.dir && cur.tx_enable_a) begin
          s_next.obj[e].flags.tx_request_bit = 1'b1;
        end
      end
      cmo_pkg::CMO_EV_TX_SELECT: begin
        if (cur.object_valid_bit) s_next.obj[e].flags.object_selected_bit = 1'b1;
      end
      cmo_pkg::CMO_EV_TX_SETUP: begin
        if (setup_ok) begin
          s_next.obj[e].flags.fresh_data_flag = 1'b0;
          s_next.tx_go   = 1'b1;
          s_next.tx_data = cur.dir;
        end else begin
          s_next.tx_abort = 1'b1;
        end
      end
      cmo_pkg::CMO_EV_TX_DONE: begin
        if (done_ok) begin
          s_next.obj[e].flags.tx_pending_flag = 1'b1;
          if (!s_next.obj[e].flags.fresh_data_flag)
            s_next.obj[e].flags.tx_request_bit = 1'b0;
          s_next.obj[e].ipr[`CMO_CFC_LO +: 16] = node_frame_counter_i;
        end
      end
      default: ;
    endcase

    if (pend_set) s_next.pend[pend_idx] = 1'b1;
    if (rst_i) s_next = reset_state();
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign ack_o             = s_reg.ack;
  assign dat_o             = s_reg.rdat;
  assign rx_accept_ok_o    = s_reg.rx_ok;
  assign tx_go_o           = s_reg.tx_go;
  assign tx_abort_o        = s_reg.tx_abort;
  assign tx_data_frame_o   = s_reg.tx_data;
  assign tx_pending_o      = s_reg.tx_pend;
  assign irq_output_line_o = s_reg.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_setup_ok;
    setup_ok;
  endsequence

  sequence s_go_out;
    ##1 tx_go_o && !tx_abort_o;
  endsequence

  a_rx_pend_set: assert property (store_ok |=> s_reg.obj[$past(e)].flags.rx_pending_flag)
    else $error("rx pending not set after store");
  a_tx_pend_set: assert property (done_ok |=> s_reg.obj[$past(e)].flags.tx_pending_flag)
    else $error("tx pending not set after success");
  a_upd_ends: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_STORE
                               |=> !s_reg.obj[$past(e)].flags.rx_updating_flag)
    else $error("rx updating still set after store");
  a_fresh_set: assert property (store_ok |=> s_reg.obj[$past(e)].flags.fresh_data_flag)
    else $error("fresh data not set after store");
  a_fresh_clear: assert property (s_setup_ok ##0 !(wb_i.cyc && wb_i.stb)
                                  |=> !s_reg.obj[$past(e)].flags.fresh_data_flag)
    else $error("fresh data not cleared at transmit start");
  a_lost_flag: assert property (store_ok && cur.fresh_data_flag
                                |=> s_reg.obj[$past(e)].flags.frame_lost_flag)
    else $error("frame lost not flagged");
  a_invalid_rx: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_ACCEPT && !cur.object_valid_bit
                                 |=> !rx_accept_ok_o)
    else $error("invalid object accepted frame");
  a_rx_enable_bit_gate: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_ACCEPT && !cur.rx_enable_bit
                                |=> !rx_accept_ok_o)
    else $error("disabled object accepted frame");
  a_skip_store: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_STORE && !cur.object_selected_bit
                                 && !(wb_i.cyc && wb_i.stb)
                                 |=> s_reg.obj[$past(e)].ipr == $past(s_reg.obj[e].ipr))
    else $error("store done on deselected object");
  a_tx_go: assert property (s_setup_ok |-> s_go_out)
    else $error("setup did not start transmission");
  a_tx_abort: assert property (ev_i.kind == cmo_pkg::CMO_EV_TX_SETUP && !setup_ok
                               |=> tx_abort_o && !tx_go_o)
    else $error("setup not abandoned");
  a_snapshot: assert property (done_ok |=> s_reg.obj[$past(e)].ipr[31:16] == $past(node_frame_counter_i))
    else $error("frame counter not captured");
  a_irq_route: assert property (rx_fire && !s_reg.obj[e].ipr[3]
                                |=> irq_output_line_o[$past(s_reg.obj[e].ipr[2:0])])
    else $error("rx interrupt not on selected line");
  a_req_keep: assert property (done_ok && cur.fresh_data_flag && !(wb_i.cyc && wb_i.stb)
                               |=> s_reg.obj[$past(e)].flags.tx_request_bit == $past(cur.tx_request_bit))
    else $error("request cleared despite fresh data");

  // ----------------------------------------
  // flag, remote and control word checks
  // ----------------------------------------
  sequence s_ctl_write;
    wb_i.cyc && wb_i.stb && wb_i.we && (s_reg.wb == cmo_pkg::CMO_WB_IDLE) && (wb_i.adr[11:10] == 2'b00)
    && (wb_i.adr[4:2] == `CMO_OFS_STAT) && (wb_i.sel == 4'hF);
  endsequence

  a_upd_set: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_UPDATE && !ev_i.remote
                              && cur.object_selected_bit && cur.object_valid_bit
                              |=> s_reg.obj[$past(e)].flags.rx_updating_flag)
    else $error("rx updating not set during update");
  a_rx_pend_keep: assert property (s_reg.obj[e].flags.rx_pending_flag && !(wb_i.cyc && wb_i.stb)
                                   |=> s_reg.obj[$past(e)].flags.rx_pending_flag)
    else $error("rx pending cleared by hardware");
  a_remote_req: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_STORE && ev_i.remote && cur.dir
                                 && cur.object_selected_bit && cur.object_valid_bit && cur.tx_enable_a
                                 |=> s_reg.obj[$past(e)].flags.tx_request_bit)
    else $error("remote frame did not set request");
  a_remote_mute: assert property (ev_i.kind == cmo_pkg::CMO_EV_RX_STORE && ev_i.remote && !cur.tx_enable_a
                                  && !cur.tx_request_bit && !(wb_i.cyc && wb_i.stb)
                                  |=> !s_reg.obj[$past(e)].flags.tx_request_bit)
    else $error("remote frame answered with enable a clear");
  a_fifo_mark: assert property (fifo_i.valid
                                |=> s_reg.obj[$past(fifo_i.obj)].flags.tx_enable_b == $past(fifo_i.active))
    else $error("fifo mark not applied");
  a_panel_list: assert property (panel_i.valid
                                 |=> s_reg.obj[$past(panel_i.obj)].list == $past(panel_i.list))
    else $error("list field not updated by panel");
  a_pend_bit: assert property (pend_set |=> s_reg.pend[$past(pend_idx)])
    else $error("pending bit not set");
  a_ctl_clear: assert property (s_ctl_write ##0 (wb_i.dat[6] && !wb_i.dat[22])
                                ##0 (ev_i.kind == cmo_pkg::CMO_EV_IDLE)
                                |=> !s_reg.obj[$past(wb_i.adr[9:5])].flags.object_selected_bit)
    else $error("control word did not clear selected");
  a_ctl_both: assert property (s_ctl_write ##0 (wb_i.dat[5] && wb_i.dat[21])
                               |=> s_reg.obj[$past(wb_i.adr[9:5])].flags.object_valid_bit
                                   == $past(s_reg.obj[wb_i.adr[9:5]].flags.object_valid_bit))
    else $error("control word changed valid with both bits");

endmodule : cmo_top
`default_nettype wire

//--- hdl/cmo_defs.svh
`ifndef CMO_DEFS_SVH
`define CMO_DEFS_SVH

// ----------------------------------------
// object array
// ----------------------------------------
`define CMO_NUM_OBJ     32
`define CMO_LAST_OBJ    8'h1F
`define CMO_IRQ_LINES   8
`define CMO_PEND_WORDS  8

// ----------------------------------------
// register map
// ----------------------------------------
`define CMO_PEND_AREA   10
`define CMO_OFS_FCR     3'h2
`define CMO_OFS_IPR     3'h3
`define CMO_OFS_STAT    3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMO_FLAG_W      12
`define CMO_RES_LO      0
`define CMO_SET_LO      16
`define CMO_RXIE_BIT    16
`define CMO_TXIE_BIT    17
`define CMO_MPN_LO      8
`define CMO_CFC_LO      16
`define CMO_IPR_RESET   32'h0000_0000
`define CMO_FCR_RESET   32'h0000_0000

`endif

//--- hdl/cmo_pkg.sv
`default_nettype none
package cmo_pkg;

  typedef struct packed {
    logic dir;
    logic tx_enable_b;
    logic tx_enable_a;
    logic tx_request_bit;
    logic rx_enable_bit;
    logic object_selected_bit;
    logic object_valid_bit;
    logic frame_lost_flag;
    logic fresh_data_flag;
    logic rx_updating_flag;
    logic tx_pending_flag;
    logic rx_pending_flag;
  } cmo_flags_s;

  typedef struct packed {
    cmo_flags_s  flags;
    logic [3:0]  list;
    logic [7:0]  prev_object_pointer;
    logic [7:0]  next_object_pointer;
    logic [31:0] ipr;
    logic [31:0] fcr;
  } cmo_obj_s;

  typedef enum logic [6:0] {
    CMO_EV_IDLE      = 7'h01,
    CMO_EV_RX_ACCEPT = 7'h02,
    CMO_EV_RX_UPDATE = 7'h04,
    CMO_EV_RX_STORE  = 7'h08,
    CMO_EV_TX_SELECT = 7'h10,
    CMO_EV_TX_SETUP  = 7'h20,
    CMO_EV_TX_DONE   = 7'h40
  } cmo_ev_e;

  typedef struct packed {
    cmo_ev_e    kind;
    logic [4:0] obj;
    logic       remote;
  } cmo_ev_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] obj;
    logic [3:0] list;
    logic [7:0] prev_object_pointer;
    logic [7:0] next_object_pointer;
  } cmo_panel_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] obj;
    logic       active;
  } cmo_fifo_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cmo_wb_req_s;

  typedef enum logic [1:0] {
    CMO_WB_IDLE = 2'b01,
    CMO_WB_ACK  = 2'b10
  } cmo_wb_e;

  typedef struct packed {
    cmo_wb_e        wb;
    logic           ack;
    logic [31:0]    rdat;
    cmo_obj_s [31:0] obj;
    logic [255:0]   pend;
    logic           rx_ok;
    logic           tx_go;
    logic           tx_abort;
    logic           tx_data;
    logic [7:0]     irq;
    logic [31:0]    tx_pend;
  } cmo_state_s;

endpackage : cmo_pkg
`default_nettype wire

//--- hdl/cmo_irq_route.sv
`include "cmo_defs.svh"
`default_nettype none
module cmo_irq_route (
  input  wire logic       rx_fire_i,
  input  wire logic       tx_fire_i,
  input  wire logic [3:0] rx_irq_line_select_i,
  input  wire logic [3:0] tx_irq_line_select_i,
  input  wire logic [7:0] pending_bit_index_i,
  output logic [7:0]      line_o,
  output logic            pend_set_o,
  output logic [7:0]      pend_idx_o
);

  // ----------------------------------------
  // code to line, reserved codes drop
  // ----------------------------------------
  function automatic logic [7:0] line_decode(input logic [3:0] code);
    logic [7:0] r;
    r = 8'h00;
    if (!code[3]) r[code[2:0]] = 1'b1;
    return r;
  endfunction : line_decode

  always_comb begin
    line_o     = (rx_fire_i ? line_decode(rx_irq_line_select_i) : 8'h00)
               | (tx_fire_i ? line_decode(tx_irq_line_select_i) : 8'h00);
    pend_set_o = rx_fire_i | tx_fire_i;
    pend_idx_o = pending_bit_index_i;
  end

endmodule : cmo_irq_route
`default_nettype wire

//--- verif/cmo_engine_model.sv
`default_nettype none
// ----------------------------------------
// protocol engine stand-in
// ----------------------------------------
module cmo_engine_model (
  input  wire logic          clk_i,
  output var cmo_pkg::cmo_ev_s ev_o,
  output logic [15:0]        node_frame_counter_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ev_o = '{kind: cmo_pkg::CMO_EV_IDLE, obj: 5'h00, remote: 1'b0};
    node_frame_counter_o = 16'h0000;
  end

  // one-cycle event pulse, counter held as a level
  task automatic send(input cmo_pkg::cmo_ev_e k, input logic [4:0] o, input logic r, input logic [15:0] c);
    @(posedge clk_i);
    ev_o <= '{kind: k, obj: o, remote: r};
    node_frame_counter_o <= c;
    @(posedge clk_i);
    ev_o <= '{kind: cmo_pkg::CMO_EV_IDLE, obj: 5'h00, remote: 1'b0};
  endtask : send
endmodule : cmo_engine_model
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk_i;
  logic                 rst_i;
  cmo_pkg::cmo_wb_req_s wb_i;
  logic                 ack_o;
  logic [31:0]          dat_o;
  cmo_pkg::cmo_ev_s     ev_i;
  cmo_pkg::cmo_panel_s  panel_i;
  cmo_pkg::cmo_fifo_s   fifo_i;
  logic [15:0]          cnt;
  logic                 rx_ok;
  logic                 tx_go;
  logic                 tx_abort;
  logic                 tx_data;
  logic [31:0]          tx_pend;
  logic [7:0]           irq;
  logic [31:0]          rd;
  int                   num_errors;
  int                   compares;

  cmo_top u_cmo_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .ack_o(ack_o), .dat_o(dat_o), .ev_i(ev_i),
    .panel_i(panel_i), .fifo_i(fifo_i), .node_frame_counter_i(cnt), .rx_accept_ok_o(rx_ok),
    .tx_go_o(tx_go), .tx_abort_o(tx_abort), .tx_data_frame_o(tx_data), .tx_pending_o(tx_pend),
    .irq_output_line_o(irq)
  );

  cmo_engine_model u_cmo_engine_model (.clk_i(clk_i), .ev_o(ev_i), .node_frame_counter_o(cnt));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = dat_o;
    wb_i <= '0;
  endtask : wb

  task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp, input string name);
    wb(1'b0, adr, 32'h0000_0000);
    chk(name, exp, rd);
  endtask : rdchk

  task automatic ev(input cmo_pkg::cmo_ev_e k, input logic [4:0] o, input logic r, input logic [15:0] c);
    u_cmo_engine_model.send(k, o, r, c);
    #1;
  endtask : ev

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic fifo(input logic [4:0] o, input logic a);
    @(posedge clk_i);
    fifo_i <= '{valid: 1'b1, obj: o, active: a};
    @(posedge clk_i);
    fifo_i <= '0;
  endtask : fifo

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(12'h01C, 32'h0100_0000, "stat0");
    rdchk(12'h03C, 32'h0200_0000, "stat1");
    rdchk(12'h3FC, 32'h1F1E_0000, "stat31");
    rdchk(12'h008, 32'h0000_0000, "fcr0");
    rdchk(12'h00C, 32'h0000_0000, "ipr0");
  endtask : t_reset

  task automatic t_rx();
    wb(1'b1, 12'h05C, 32'h00A0_0000);
    wb(1'b1, 12'h05C, 32'h0020_0020);
    rdchk(12'h05C, 32'h0301_00A0, "ctl");
    wb(1'b1, 12'h048, 32'h0001_0000);
    wb(1'b1, 12'h04C, 32'h0000_2503);
    ev(cmo_pkg::CMO_EV_RX_ACCEPT, 5'h02, 1'b0, 16'h1234);
    chk("acc", 32'h1, {31'h0, rx_ok});
    ev(cmo_pkg::CMO_EV_RX_UPDATE, 5'h02, 1'b0, 16'h1234);
    rdchk(12'h05C, 32'h0301_00E4, "upd");
    ev(cmo_pkg::CMO_EV_RX_STORE, 5'h02, 1'b0, 16'h1234);
    chk("irq", 32'h08, {24'h0, irq});
    rdchk(12'h05C, 32'h0301_00E9, "store");
    rdchk(12'h04C, 32'h1234_2503, "snap");
    rdchk(12'h404, 32'h0000_0020, "pend");
    wb(1'b1, 12'h404, 32'h0000_0020);
    rdchk(12'h404, 32'h0000_0000, "pclr");
    ev(cmo_pkg::CMO_EV_RX_STORE, 5'h02, 1'b0, 16'h5678);
    rdchk(12'h05C, 32'h0301_00F9, "lost");
    wb(1'b1, 12'h05C, 32'h0000_0040);
    ev(cmo_pkg::CMO_EV_RX_STORE, 5'h02, 1'b0, 16'h9999);
    rdchk(12'h05C, 32'h0301_00B9, "skip");
    rdchk(12'h04C, 32'h5678_2503, "nosnap");
  endtask : t_rx

  task automatic t_refuse();
    wb(1'b1, 12'h07C, 32'h0020_0000);
    wb(1'b1, 12'h0BC, 32'h0080_0000);
    ev(cmo_pkg::CMO_EV_RX_ACCEPT, 5'h03, 1'b0, 16'h0001);
    chk("noen", 32'h0, {31'h0, rx_ok});
    ev(cmo_pkg::CMO_EV_RX_ACCEPT, 5'h05, 1'b0, 16'h0001);
    chk("noval", 32'h0, {31'h0, rx_ok});
    rdchk(12'h0BC, 32'h0604_0080, "nosel");
  endtask : t_refuse

  task automatic t_tx();
    wb(1'b1, 12'h09C, 32'h0F28_0000);
    tick();
    chk("txp", 32'h10, tx_pend);
    wb(1'b1, 12'h09C, 32'h0000_0200);
    tick();
    chk("txa", 32'h0, tx_pend);
    wb(1'b1, 12'h09C, 32'h0200_0000);
    fifo(5'h04, 1'b0);
    tick();
    chk("txb", 32'h0, tx_pend);
    fifo(5'h04, 1'b1);
    ev(cmo_pkg::CMO_EV_TX_SETUP, 5'h04, 1'b0, 16'h0000);
    chk("abort", 32'h1, {31'h0, tx_abort});
    ev(cmo_pkg::CMO_EV_TX_SELECT, 5'h04, 1'b0, 16'h0000);
    ev(cmo_pkg::CMO_EV_TX_SETUP, 5'h04, 1'b0, 16'h0000);
    chk("go", 32'h1, {31'h0, tx_go});
    chk("dfr", 32'h1, {31'h0, tx_data});
    rdchk(12'h09C, 32'h0503_0F60, "setup");
    ev(cmo_pkg::CMO_EV_TX_DONE, 5'h04, 1'b0, 16'h0ABC);
    rdchk(12'h09C, 32'h0503_0E62, "done");
    rdchk(12'h08C, 32'h0ABC_0000, "txsnap");
    wb(1'b1, 12'h09C, 32'h0100_0000);
    ev(cmo_pkg::CMO_EV_TX_SELECT, 5'h04, 1'b0, 16'h0000);
    ev(cmo_pkg::CMO_EV_TX_SETUP, 5'h04, 1'b0, 16'h0000);
    wb(1'b1, 12'h09C, 32'h0008_0000);
    ev(cmo_pkg::CMO_EV_TX_DONE, 5'h04, 1'b0, 16'h0BCD);
    rdchk(12'h09C, 32'h0503_0F6A, "keep");
  endtask : t_tx

  task automatic t_remote();
    wb(1'b1, 12'h09C, 32'h0080_0100);
    ev(cmo_pkg::CMO_EV_RX_ACCEPT, 5'h04, 1'b1, 16'h0000);
    chk("racc", 32'h1, {31'h0, rx_ok});
    ev(cmo_pkg::CMO_EV_RX_STORE, 5'h04, 1'b1, 16'h0000);
    rdchk(12'h09C, 32'h0503_0FEA, "rreq");
    wb(1'b1, 12'h09C, 32'h0000_0300);
    ev(cmo_pkg::CMO_EV_RX_ACCEPT, 5'h04, 1'b1, 16'h0000);
    ev(cmo_pkg::CMO_EV_RX_STORE, 5'h04, 1'b1, 16'h0000);
    rdchk(12'h09C, 32'h0503_0CEA, "rnoa");
    wb(1'b1, 12'h05C, 32'h0700_0000);
    ev(cmo_pkg::CMO_EV_TX_SELECT, 5'h02, 1'b0, 16'h0000);
    ev(cmo_pkg::CMO_EV_TX_SETUP, 5'h02, 1'b0, 16'h0000);
    chk("rgo", 32'h1, {31'h0, tx_go});
    chk("rfr", 32'h0, {31'h0, tx_data});
  endtask : t_remote

  task automatic t_misc();
    @(posedge clk_i);
    panel_i <= '{valid: 1'b1, obj: 5'h06, list: 4'h5, prev_object_pointer: 8'h10, next_object_pointer: 8'h20};
    @(posedge clk_i);
    panel_i <= '0;
    rdchk(12'h0DC, 32'h2010_5000, "list");
    wb(1'b1, 12'h424, 32'hFFFF_FFFF);
    rdchk(12'h424, 32'h0000_0000, "unmap");
    rdchk(12'h404, 32'h0000_0020, "pkeep");
    rdchk(12'h000, 32'h0000_0000, "hole");
  endtask : t_misc

  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    num_errors = 0;
    compares = 0;
    rst_i = 1'b1;
    wb_i = '0;
    panel_i = '0;
    fifo_i = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rx();
    t_refuse();
    t_tx();
    t_remote();
    t_misc();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
